// ### rtl/sbs_pkg.sv
// Package with sizes, reset values and modes of the pipelined burst memory port.
package sbs_pkg;
  localparam int          SBS_ADDR_W   = 17;
  localparam int          SBS_WORDS    = 131072;
  localparam int          SBS_LANES    = 4;
  localparam int          SBS_LANE_W   = 9;
  localparam int          SBS_DATA_W   = 36;
  localparam int          SBS_BYTE_W   = 8;
  localparam logic [1:0]  SBS_CNT_RST  = 2'h0;
  localparam logic [1:0]  SBS_CNT_ONE  = 2'h1;
  localparam logic [16:0] SBS_ADDR_RST = 17'h00000;
  localparam logic [35:0] SBS_DATA_RST = 36'h000000000;
  localparam logic [3:0]  SBS_LANE_RST = 4'h0;
  // Write pending phases: none, waiting for the second edge of a processor write.
  typedef enum logic [1:0] {
    SBS_WR_IDLE = 2'b01,
    SBS_WR_ARM  = 2'b10
  } sbs_wr_state_t;
endpackage : sbs_pkg

// ### rtl/sbs_port.sv
// Synchronous pipelined burst memory port with a 128K x 36 array.
// Summary of operation
// - Register address, data and controls each edge.
// - Array holds 128K words of 36 bits.
// - Controller strobe loads address and burst counter.
// - Processor strobe loads address and burst counter.
// - Processor strobe wins when both strobes low.
// - Processor strobe ignored while select A high.
// - Strobe opens burst, step paces internal addresses.
// - Step asserted increments the burst address.
// - Two-bit counter, four transfers from base.
// - Mode input picks interleaved or linear order.
// - Selected only with A, C low, B high.
// - Global write writes all 36 bits.
// - Each low lane select writes its lane.
// - Lane selects count only with gate low.
// - Writes timed internally, synchronous to clock.
// - Write data enters through an input register.
// - Read data leaves through an output register.
// - Three register stages from address to output.
// - Output drive low enables pins three edges later, through synchroniser and register.
// - Sleep request gives low power, keeps contents.
// - Global write overrides gate and lane selects.
// - Processor write completes on the second edge.
// - Controller write completes in one cycle.
`timescale 1ns/1ps
module sbs_port
  import sbs_pkg::*;
(
  input  wire logic                  CLOCK,
  input  wire logic                  RST,
  input  wire logic [SBS_ADDR_W-1:0] ADDRESS,
  input  wire logic                  CONTROLLER_ADDRESS_STROBE_N,
  input  wire logic                  PROCESSOR_ADDRESS_STROBE_N,
  input  wire logic                  BURST_STEP,
  input  wire logic                  CHIP_SELECT_A_N,
  input  wire logic                  CHIP_SELECT_B,
  input  wire logic                  CHIP_SELECT_C_N,
  input  wire logic                  ALL_BYTES_WRITE_N,
  input  wire logic [SBS_LANES-1:0]  BYTE_LANE_WRITE_N,
  input  wire logic                  BYTE_WRITE_GATE_N,
  input  wire logic                  MODE,
  input  wire logic                  OUTPUT_DRIVE_N,
  input  wire logic                  SLEEP_REQUEST,
  input  wire logic [SBS_DATA_W-1:0] DATA_IN,
  output logic      [SBS_DATA_W-1:0] DATA_OUT,
  output logic      [SBS_LANES-1:0]  DATA_OE,
  output logic                       SLEEP_ACTIVE
);

  // Input capture registers, loaded every edge.
  logic [SBS_ADDR_W-1:0] addr_in_q, addr_in_d;
  logic [SBS_DATA_W-1:0] din_q, din_d;
  logic                  controller_address_strobe_n_n_q, controller_address_strobe_n_n_d, processor_address_strobe_n_n_q, processor_address_strobe_n_n_d, step_q, step_d;
  logic                  csa_n_q, csa_n_d, csb_q, csb_d, csc_n_q, csc_n_d;
  logic                  gw_n_q, gw_n_d, gate_n_q, gate_n_d;
  logic [SBS_LANES-1:0]  lane_n_q, lane_n_d;
  // Two-flop synchronisers for the static mode pin and the async control pins.
  logic [1:0]            mode_s_q, mode_s_d, oe_s_q, oe_s_d, zz_s_q, zz_s_d;

  always_comb begin
    addr_in_d = ADDRESS;
    din_d     = DATA_IN;
    controller_address_strobe_n_n_d  = CONTROLLER_ADDRESS_STROBE_N;
    processor_address_strobe_n_n_d  = PROCESSOR_ADDRESS_STROBE_N;
    step_d    = BURST_STEP;
    csa_n_d   = CHIP_SELECT_A_N;
    csb_d     = CHIP_SELECT_B;
    csc_n_d   = CHIP_SELECT_C_N;
    gw_n_d    = ALL_BYTES_WRITE_N;
    gate_n_d  = BYTE_WRITE_GATE_N;
    lane_n_d  = BYTE_LANE_WRITE_N;
    mode_s_d  = {mode_s_q[0], MODE};
    oe_s_d    = {oe_s_q[0], ~OUTPUT_DRIVE_N};
    zz_s_d    = {zz_s_q[0], SLEEP_REQUEST};
  end

  // Strobes reset inactive so no access is decoded straight after reset.
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      addr_in_q <= SBS_ADDR_RST;
      din_q     <= SBS_DATA_RST;
      controller_address_strobe_n_n_q  <= 1'b1;
      processor_address_strobe_n_n_q  <= 1'b1;
      step_q    <= 1'b0;
      csa_n_q   <= 1'b1;
      csb_q     <= 1'b0;
      csc_n_q   <= 1'b1;
      gw_n_q    <= 1'b1;
      gate_n_q  <= 1'b1;
      lane_n_q  <= {SBS_LANES{1'b1}};
      mode_s_q  <= 2'h0;
      oe_s_q    <= 2'h0;
      zz_s_q    <= 2'h0;
    end else begin
      addr_in_q <= addr_in_d;
      din_q     <= din_d;
      controller_address_strobe_n_n_q  <= controller_address_strobe_n_n_d;
      processor_address_strobe_n_n_q  <= processor_address_strobe_n_n_d;
      step_q    <= step_d;
      csa_n_q   <= csa_n_d;
      csb_q     <= csb_d;
      csc_n_q   <= csc_n_d;
      gw_n_q    <= gw_n_d;
      gate_n_q  <= gate_n_d;
      lane_n_q  <= lane_n_d;
      mode_s_q  <= mode_s_d;
      oe_s_q    <= oe_s_d;
      zz_s_q    <= zz_s_d;
    end
  end

  // Decode of the captured controls.
  logic selected, p_load, c_load, any_load, sleeping, wr_req;
  logic [SBS_LANES-1:0] lane_en;
  assign selected = ~csa_n_q & csb_q & ~csc_n_q;
  assign sleeping = zz_s_q[1];
  assign p_load   = ~processor_address_strobe_n_n_q & ~csa_n_q & ~sleeping;
  // A processor strobe ignored under select A high leaves the controller strobe in force.
  assign c_load   = ~controller_address_strobe_n_n_q & (processor_address_strobe_n_n_q | csa_n_q) & ~sleeping;
  assign any_load = p_load | c_load;
  assign lane_en  = ~gw_n_q ? {SBS_LANES{1'b1}}
                  : (~gate_n_q ? ~lane_n_q : SBS_LANE_RST);
  assign wr_req   = |lane_en;

  // Burst state: base address, transfer count, active flag, write phase.
  logic [SBS_ADDR_W-1:0] base_q, base_d;
  logic [1:0]            cnt_q, cnt_d, low_bits;
  logic                  active_q, active_d;
  sbs_wr_state_t         wst_q, wst_d;
  logic                  do_write, do_read;
  logic [SBS_ADDR_W-1:0] acc_addr;

  assign low_bits = mode_s_q[1] ? (base_q[1:0] ^ cnt_q) : 2'(base_q[1:0] + cnt_q);
  assign acc_addr = {base_q[SBS_ADDR_W-1:2], low_bits};

  always_comb begin
    base_d   = base_q;
    cnt_d    = cnt_q;
    active_d = active_q;
    wst_d    = SBS_WR_IDLE;
    do_write = 1'b0;
    do_read  = 1'b0;
    if (any_load) begin
      base_d   = addr_in_q;
      cnt_d    = SBS_CNT_RST;
      active_d = selected;
      // A processor load never writes now; its write is issued in the SBS_WR_ARM cycle and lands two edges on.
      if (selected && p_load) begin
        wst_d = SBS_WR_ARM;
      end
      do_write = selected & c_load & wr_req;
      do_read  = selected & ~do_write & ~p_load;
    end else if (active_q && !sleeping) begin
      unique case (wst_q)
        SBS_WR_ARM: begin
          // Second edge of a processor access: write or read the base word.
          do_write = wr_req;
          do_read  = ~wr_req;
        end
        SBS_WR_IDLE: begin
          if (step_q) begin
            cnt_d = 2'(cnt_q + SBS_CNT_ONE);
          end
          do_write = wr_req;
          do_read  = ~wr_req;
        end
      endcase
    end
  end

  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      base_q   <= SBS_ADDR_RST;
      cnt_q    <= SBS_CNT_RST;
      active_q <= 1'b0;
      wst_q    <= SBS_WR_IDLE;
    end else begin
      base_q   <= base_d;
      cnt_q    <= cnt_d;
      active_q <= active_d;
      wst_q    <= wst_d;
    end
  end

  // array storage, flip-flops without reset so contents survive sleep.
  logic [SBS_DATA_W-1:0] mem [SBS_WORDS];
  logic [SBS_ADDR_W-1:0] wr_addr;
  logic [SBS_ADDR_W-1:0] rd_addr;
  assign wr_addr = (any_load & c_load) ? addr_in_q
                 : ((wst_q == SBS_WR_ARM) ? base_q : acc_addr);
  assign rd_addr = any_load ? addr_in_q : acc_addr;

  // self-timed lane writes from the input register.
  always_ff @(posedge CLOCK) begin
    for (int l = 0; l < SBS_LANES; l++) begin
      if (do_write && lane_en[l]) begin
        mem[wr_addr][l*SBS_LANE_W +: SBS_LANE_W] <= din_q[l*SBS_LANE_W +: SBS_LANE_W];
      end
    end
  end

  // Output pipeline: read register then output register.
  logic [SBS_DATA_W-1:0] rd_q, rd_d, dout_q, dout_d;
  logic                  rv_q, rv_d;
  logic [SBS_LANES-1:0]  oe_q, oe_d;
  logic                  zz_q, zz_d;

  // two stages, drive enable, sleep flag
  always_comb begin
    rd_d   = do_read ? mem[rd_addr] : rd_q;
    rv_d   = do_read;
    dout_d = rv_q ? rd_q : dout_q;
    // Enable follows the synchronised drive pin; outputs float while deselected.
    oe_d   = {SBS_LANES{oe_s_q[1] & rv_q & ~sleeping}};
    zz_d   = sleeping;
  end

  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      rd_q   <= SBS_DATA_RST;
      rv_q   <= 1'b0;
      dout_q <= SBS_DATA_RST;
      oe_q   <= SBS_LANE_RST;
      zz_q   <= 1'b0;
    end else begin
      rd_q   <= rd_d;
      rv_q   <= rv_d;
      dout_q <= dout_d;
      oe_q   <= oe_d;
      zz_q   <= zz_d;
    end
  end

  assign DATA_OUT     = dout_q;
  assign DATA_OE      = oe_q;
  assign SLEEP_ACTIVE = zz_q;

  // Assertions on the sequencing.
  // processor wins
  property p_proc_wins;
    @(posedge CLOCK) disable iff (RST) (!processor_address_strobe_n_n_q && !csa_n_q) |-> !c_load;
  endproperty
  a_proc_wins: assert property (p_proc_wins) else $error("controller strobe not ignored");
  property p_csa_gate;
    @(posedge CLOCK) disable iff (RST) csa_n_q |-> !p_load;
  endproperty
  a_csa_gate: assert property (p_csa_gate) else $error("processor strobe not gated");
  property p_deselect;
    @(posedge CLOCK) disable iff (RST) (any_load && !selected) |=> (!active_q && !rv_q);
  endproperty
  a_deselect: assert property (p_deselect) else $error("deselected load still active");
  property p_proc_two;
    @(posedge CLOCK) disable iff (RST) (p_load && selected) |-> !do_write ##1 (wst_q == SBS_WR_ARM);
  endproperty
  a_proc_two: assert property (p_proc_two) else $error("processor write not two cycles");
  property p_hold;
    @(posedge CLOCK) disable iff (RST) (!any_load && !step_q) |=> $stable(cnt_q);
  endproperty
  a_hold: assert property (p_hold) else $error("burst count moved without step");
  property p_step;
    @(posedge CLOCK) disable iff (RST)
      (!any_load && step_q && active_q && !sleeping && wst_q == SBS_WR_IDLE)
      |=> cnt_q == 2'($past(cnt_q) + 2'h1);
  endproperty
  a_step: assert property (p_step) else $error("burst count did not step");
  property p_load_base;
    @(posedge CLOCK) disable iff (RST) any_load |=> (cnt_q == 2'h0 && base_q == $past(addr_in_q));
  endproperty
  a_load_base: assert property (p_load_base) else $error("strobe did not load address");
  // read reaches output two edges later
  property p_pipe;
    @(posedge CLOCK) disable iff (RST) do_read |=> rv_q ##1 (dout_q == $past(rd_q));
  endproperty
  a_pipe: assert property (p_pipe) else $error("read pipeline wrong");
  property p_global;
    @(posedge CLOCK) disable iff (RST) !gw_n_q |-> lane_en == 4'hF;
  endproperty
  a_global: assert property (p_global) else $error("global write not all lanes");
  // gate closed means no lane write
  property p_gate;
    @(posedge CLOCK) disable iff (RST) (gw_n_q && gate_n_q) |-> !wr_req;
  endproperty
  a_gate: assert property (p_gate) else $error("lane write without gate");
  c_ctrl_write: cover property (@(posedge CLOCK) c_load && selected && wr_req);
  c_proc_write: cover property (@(posedge CLOCK) wst_q == SBS_WR_ARM && wr_req);
  c_burst_wrap: cover property (@(posedge CLOCK) step_q && cnt_q == 2'h3);
  c_sleep:      cover property (@(posedge CLOCK) zz_q);

endmodule : sbs_port

// ### bench/sbs_master.sv
// Bus master model that drives the memory port one clock at a time.
`timescale 1ns/1ps
module sbs_master
  import sbs_pkg::*;
(
  input  wire logic             clk,
  output logic [SBS_ADDR_W-1:0] adr,
  output logic                  cs_n,
  output logic                  ps_n,
  output logic                  stp,
  output logic                  gw_n,
  output logic [SBS_LANES-1:0]  bw_n,
  output logic                  bg_n,
  output logic [SBS_DATA_W-1:0] din
);
  // Start idle: no strobe, no write, no step.
  initial {adr, cs_n, ps_n, stp, gw_n, bw_n, bg_n, din} = {17'h0, 3'h6, 1'h1, 4'hF, 1'h1, 36'h0};

  // one bus cycle
  // Everything changes just after an edge and holds until the next one.
  task automatic cyc(logic [16:0] a, logic c, logic p, logic s, logic g, logic [3:0] b,
                     logic e, logic [35:0] d);
    @(posedge clk);
    adr  <= a;
    cs_n <= c;
    ps_n <= p;
    stp  <= s;
    gw_n <= g;
    bw_n <= b;
    bg_n <= e;
    din  <= d;
  endtask : cyc

  // Address and data show the inverse of their last value, so a stale sample never matches.
  task automatic idle();
    cyc(~adr, 1'b1, 1'b1, 1'b0, 1'b1, 4'hF, 1'b1, ~din);
  endtask : idle
endmodule : sbs_master

// ### bench/test_sbs_port.sv
// Self-checking bench for the pipelined burst memory port.
`timescale 1ns/1ps
module test_sbs_port
  import sbs_pkg::*;
;
  logic        CLOCK = 1'b0;
  logic        RST = 1'b1;
  logic        sa_n = 1'b0;
  logic        sb = 1'b1;
  logic        sc_n = 1'b0;
  logic        mode = 1'b0;
  logic        oe_n = 1'b0;
  logic        slp = 1'b0;
  logic [31:0] rs = 32'h0000001C;
  logic [35:0] dd;
  logic [16:0] bs;
  logic [35:0] mem [int];
  int          err_total = 0;
  int          n_tests = 0;
  logic [16:0] adr;
  logic        cs_n, ps_n, stp, gw_n, bg_n, SLEEP_ACTIVE;
  logic [3:0]  bw_n, DATA_OE;
  logic [35:0] din, DATA_OUT;

  // Clock at 40 MHz.
  always #12.5 CLOCK = ~CLOCK;

  sbs_master m (.clk(CLOCK), .adr(adr), .cs_n(cs_n), .ps_n(ps_n), .stp(stp), .gw_n(gw_n),
                .bw_n(bw_n), .bg_n(bg_n), .din(din));
  sbs_port dut (.CLOCK(CLOCK), .RST(RST), .ADDRESS(adr), .CONTROLLER_ADDRESS_STROBE_N(cs_n),
    .PROCESSOR_ADDRESS_STROBE_N(ps_n), .BURST_STEP(stp), .CHIP_SELECT_A_N(sa_n),
    .CHIP_SELECT_B(sb), .CHIP_SELECT_C_N(sc_n), .ALL_BYTES_WRITE_N(gw_n),
    .BYTE_LANE_WRITE_N(bw_n), .BYTE_WRITE_GATE_N(bg_n), .MODE(mode), .OUTPUT_DRIVE_N(oe_n),
    .SLEEP_REQUEST(slp), .DATA_IN(din), .DATA_OUT(DATA_OUT), .DATA_OE(DATA_OE),
    .SLEEP_ACTIVE(SLEEP_ACTIVE));

  // Xorshift source, fixed seed, so every run repeats.
  function automatic logic [35:0] r36();
    logic [71:0] t;
    for (int k = 0; k < 2; k++) begin
      rs = rs ^ (rs << 13);
      rs = rs ^ (rs >> 17);
      rs = rs ^ (rs << 5);
      t = {t[39:0], rs};
    end
    return t[35:0];
  endfunction : r36

  // Expected word after a write: global takes all lanes, gated lanes take their own.
  function automatic logic [35:0] mrg(logic [35:0] o, logic [35:0] d, logic g,
                                      logic [3:0] b, logic e);
    mrg = o;
    for (int l = 0; l < SBS_LANES; l++) begin
      if (!g || (!e && !b[l])) mrg[l*SBS_LANE_W +: SBS_LANE_W] = d[l*SBS_LANE_W +: SBS_LANE_W];
    end
  endfunction : mrg

  // Burst location: linear adds, interleaved exclusive-ORs the count.
  function automatic logic [16:0] nxt(logic [16:0] a, logic [1:0] i, logic md);
    return {a[16:2], md ? a[1:0] ^ i : a[1:0] + i};
  endfunction : nxt

  task automatic chk(string nm, logic [35:0] s, logic [35:0] e);
    n_tests++;
    if (s !== e) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", nm, e, s);
    end
  endtask : chk

  task automatic cwr(logic [16:0] a, logic g, logic [3:0] b, logic e, logic [35:0] d);
    m.cyc(a, 1'b0, 1'b1, 1'b0, g, b, e, d);
    mem[a] = mrg(mem[a], d, g, b, e);
    m.idle();
  endtask : cwr

  // First cycle carries live write controls that must be ignored; both picks dual strobes.
  task automatic pwr(logic [16:0] a, logic g, logic [3:0] b, logic e, logic [35:0] d,
                     logic both);
    m.cyc(a, ~both, 1'b0, 1'b0, 1'b0, 4'h0, 1'b0, ~d);
    m.cyc(~a, 1'b1, 1'b1, 1'b0, g, b, e, d);
    mem[a] = mrg(mem[a], d, g, b, e);
    m.idle();
  endtask : pwr

  // Controller read of n burst words; word j shows after edge 4+j from the strobe drive.
  task automatic rd(logic [16:0] a, int n);
    m.cyc(a, 1'b0, 1'b1, 1'b0, 1'b1, 4'hF, 1'b1, ~m.din);
    for (int i = 1; i <= n + 3; i++) begin
      m.cyc(~a, 1'b1, 1'b1, i < n, 1'b1, 4'hF, 1'b1, ~m.din);
      if (i >= 4) begin
        #1 chk("data", DATA_OUT, mem[nxt(a, 2'(i - 4), mode)]);
        chk("drive", 36'(DATA_OE), oe_n ? 36'h0 : 36'hF);
      end
    end
  endtask : rd

  task automatic conclude();
    $display("comparisons %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : conclude

  // The sequence needs well under 1000 cycles; 4000 means a hang.
  initial begin
    #(25 * 4000);
    err_total++;
    conclude();
  end

  initial begin
    repeat (6) @(posedge CLOCK);
    RST <= 1'b0;
    #1 chk("drive after reset", 36'(DATA_OE), 36'h0);
    dd = r36();
    bs = dd[16:0];
    for (int i = 0; i < 4; i++) cwr({bs[16:2], 2'(i)}, 1'b0, 4'hF, 1'b1, r36());
    // Mode is synchronised, so give it a few edges before each burst.
    for (int md = 0; md < 2; md++) begin
      m.idle();
      mode <= md[0];
      repeat (3) m.idle();
      dd = r36();
      rd({bs[16:2], dd[1:0]}, 4);
    end
    // Random write mixes through both strobes, with fixed corners first.
    cwr(bs, 1'b0, 4'hF, 1'b1, r36());
    rd(bs, 1);
    cwr(bs, 1'b0, 4'hA, 1'b0, r36());
    rd(bs, 1);
    pwr(bs, 1'b1, 4'hF, 1'b1, r36(), 1'b1);
    rd(bs, 1);
    for (int i = 0; i < 12; i++) begin
      dd = r36();
      if (i[0]) cwr({bs[16:2], dd[1:0]}, dd[4], dd[8:5], dd[9], r36());
      else pwr({bs[16:2], dd[1:0]}, dd[4], dd[8:5], dd[9], r36(), 1'b0);
      rd({bs[16:2], dd[1:0]}, 1);
    end
    // Each enable wrong in turn: the global write must be dropped.
    // With select A high both strobes fall, so the controller strobe must deselect.
    for (int k = 0; k < 3; k++) begin
      m.idle();
      sa_n <= (k == 0);
      sb <= (k != 1);
      sc_n <= (k == 2);
      m.cyc(bs, 1'b0, k != 0, 1'b0, 1'b0, 4'h0, 1'b0, ~mem[bs]);
      m.idle();
      sa_n <= 1'b0;
      sb <= 1'b1;
      sc_n <= 1'b0;
    end
    rd(bs, 1);
    m.idle();
    oe_n <= 1'b1;
    repeat (3) m.idle();
    rd(bs, 1);
    m.idle();
    oe_n <= 1'b0;
    slp <= 1'b1;
    repeat (4) m.idle();
    #1 chk("sleep", 36'(SLEEP_ACTIVE), 36'h1);
    m.idle();
    slp <= 1'b0;
    repeat (4) m.idle();
    #1 chk("wake", 36'(SLEEP_ACTIVE), 36'h0);
    rd({bs[16:2], 2'h0}, 4);
    conclude();
  end
endmodule : test_sbs_port
